// >>> hw/cwd_cfg_map.svh
// Offsets, field positions and reset values of the configuration decoder.
// Assumes byte addresses on a 32-bit AXI4-Lite bus, one word per register.
`ifndef CWD_CFG_MAP_SVH
`define CWD_CFG_MAP_SVH

// Register byte offsets
`define CWD_OFF_CFG_WORD  8'h00
`define CWD_OFF_STATUS    8'h04
`define CWD_OFF_PWR_CTRL  8'h08
`define CWD_OFF_VFY_ADDR  8'h0C
`define CWD_OFF_VFY_DATA  8'h10

// Configuration word field positions
`define CWD_BIT_PROTECT_N 13
`define CWD_BIT_CCP_MUX   12
`define CWD_BIT_DEBUG_N   11
`define CWD_BIT_BORV_HI   8
`define CWD_BIT_BORV_LO   7
`define CWD_BIT_BOR_EN    6
`define CWD_BIT_RST_PIN   5
`define CWD_BIT_OSC2      4
`define CWD_BIT_POWERUP_TIMER_N    3
`define CWD_BIT_WDT_EN    2
`define CWD_BIT_OSC1      1
`define CWD_BIT_OSC0      0

// Bits that do not exist and read back as one
`define CWD_UNIMP_MASK    14'h0600

// Protected range tops and debugger reserve
`define CWD_PROT_TOP_BIG  13'h1FFF
`define CWD_PROT_TOP_SML  13'h0FFF
`define CWD_DBG_RSV_WORDS 13'h0100

// Reset values
`define CWD_CFG_RST       14'h3FFF
`define CWD_PWR_CTRL_RST  1'h0
`define CWD_VFY_ADDR_RST  13'h0000
`define CWD_VFY_DATA_RST  14'h0000

// Bus responses
`define CWD_RESP_OKAY     2'h0
`define CWD_RESP_SLVERR   2'h2

`endif

// >>> hw/cwd_pkg.sv
// Types shared by the configuration decoder files.
// Assumes nothing beyond a SystemVerilog compiler.
package cwd_pkg;

  // Oscillator source and pin use
  typedef enum logic [2:0] {
    CWD_OSC_LP_XTAL    = 3'b000,
    CWD_OSC_STD_XTAL   = 3'b001,
    CWD_OSC_HS_XTAL    = 3'b010,
    CWD_OSC_EXT_CLK    = 3'b011,
    CWD_OSC_INTERNAL_RC_OSC_IO   = 3'b100,
    CWD_OSC_INTERNAL_RC_OSC_CLOCK_OUT = 3'b101,
    CWD_OSC_EXTERNAL_RC_OSC_IO   = 3'b110,
    CWD_OSC_EXTERNAL_RC_OSC_CLOCK_OUT = 3'b111
  } cwd_osc_e;

  // Brown-out enable policy
  typedef enum logic [1:0] {
    CWD_BOR_OFF      = 2'b00,
    CWD_BOR_SOFT     = 2'b01,
    CWD_BOR_RUN_ONLY = 2'b10,
    CWD_BOR_ALWAYS   = 2'b11
  } cwd_bor_e;

  // Brown-out trip level
  typedef enum logic [1:0] {
    CWD_BORV_4V5 = 2'b00,
    CWD_BORV_4V2 = 2'b01,
    CWD_BORV_2V7 = 2'b10,
    CWD_BORV_2V0 = 2'b11
  } cwd_borv_e;

  // Configuration load sequence
  typedef enum logic {
    CWD_LD_WAIT = 1'b0,
    CWD_LD_DONE = 1'b1
  } cwd_load_e;

endpackage

// >>> hw/cwd_field_decode.sv
// Pure decode of a captured configuration word into named controls.
// Assumes the word is held stable by the caller; no state inside.
`timescale 1ns/1ns
`include "cwd_cfg_map.svh"
module cwd_field_decode (
  // Captured word
  input  wire logic [13:0]      i_word,
  input  wire logic             i_brownout_mode_cfg,
  // Decoded controls
  output cwd_pkg::cwd_osc_e     o_osc,
  output cwd_pkg::cwd_bor_e     o_bor,
  output cwd_pkg::cwd_borv_e    o_borv,
  output logic                  o_protect,
  output logic                  o_ccp_on_portc,
  output logic                  o_debug_en,
  output logic                  o_rst_pin_ext,
  output logic                  o_powerup_timer_en,
  output logic                  o_wdt_en,
  output logic                  o_clock_out,
  output logic                  o_osc_one_port,
  output logic                  o_osc_two_port
);

  // Scattered three-bit oscillator field
  wire logic [2:0] osc_code = {i_word[`CWD_BIT_OSC2],
                               i_word[`CWD_BIT_OSC1],
                               i_word[`CWD_BIT_OSC0]};

  assign o_osc  = cwd_pkg::cwd_osc_e'(osc_code); // RL10 RL11
  assign o_bor  = cwd_pkg::cwd_bor_e'({i_word[`CWD_BIT_BOR_EN],
                                       i_brownout_mode_cfg}); // RL6
  assign o_borv = cwd_pkg::cwd_borv_e'(
    i_word[`CWD_BIT_BORV_HI:`CWD_BIT_BORV_LO]); // RL5
  // Zero means protected
  assign o_protect      = ~i_word[`CWD_BIT_PROTECT_N]; // RL1
  assign o_ccp_on_portc = i_word[`CWD_BIT_CCP_MUX]; // RL2
  // Zero means debugger on
  assign o_debug_en     = ~i_word[`CWD_BIT_DEBUG_N]; // RL3
  assign o_rst_pin_ext  = i_word[`CWD_BIT_RST_PIN]; // RL7
  assign o_powerup_timer_en      = ~i_word[`CWD_BIT_POWERUP_TIMER_N]; // RL8
  assign o_wdt_en       = i_word[`CWD_BIT_WDT_EN]; // RL9
  // Clock-out only on the two clock-out codes
  assign o_clock_out    = osc_code[2] & osc_code[0]; // RL10
  // Internal RC frees the first oscillator pin
  assign o_osc_one_port = osc_code[2] & ~osc_code[1]; // RL10
  // Second pin free for 110, 100 and 011
  assign o_osc_two_port = (osc_code[2] & ~osc_code[0]) |
                          (osc_code == 3'h3); // RL10 RL11

endmodule

// >>> hw/cwd_axil_slave.sv
// AXI4-Lite slave front end: takes one write and one read at a time.
// Assumes the register file answers combinationally in the same cycle.
`timescale 1ns/1ns
`include "cwd_cfg_map.svh"
module cwd_axil_slave (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // Write address and data
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  // Write response
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  // Read address and data
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // Register file side
  output logic             o_wr_en,
  output logic [7:0]       o_wr_addr,
  output logic [31:0]      o_wr_data,
  output logic [3:0]       o_wr_strb,
  input  wire logic [1:0]  i_wr_resp,
  output logic             o_rd_en,
  output logic [7:0]       o_rd_addr,
  input  wire logic [31:0] i_rd_data,
  input  wire logic [1:0]  i_rd_resp
);

  logic aw_q, w_q;  // Address / data held
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // Refuse new writes while one is pending or unanswered
  assign o_awready = ~aw_q & ~o_bvalid;
  assign o_wready  = ~w_q & ~o_bvalid;
  assign o_wr_en   = aw_q & w_q & ~o_bvalid;
  assign o_wr_addr = awaddr_q;
  assign o_wr_data = wdata_q;
  assign o_wr_strb = wstrb_q;
  assign o_arready = ~o_rvalid;
  assign o_rd_en   = i_arvalid & o_arready;
  assign o_rd_addr = i_araddr;

  // Write channels, either order
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_q <= 1'b0; w_q <= 1'b0; o_bvalid <= 1'b0;
      awaddr_q <= 8'h00; wdata_q <= 32'h0; wstrb_q <= 4'h0;
      o_bresp <= `CWD_RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_q <= 1'b1; awaddr_q <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_q <= 1'b1; wdata_q <= i_wdata; wstrb_q <= i_wstrb;
      end
      if (o_wr_en) begin
        aw_q <= 1'b0; w_q <= 1'b0;
        o_bvalid <= 1'b1; o_bresp <= i_wr_resp;
      end else if (i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // Read channel, data registered one cycle after the address
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rvalid <= 1'b0; o_rdata <= 32'h0; o_rresp <= `CWD_RESP_OKAY;
    end else if (o_rd_en) begin
      o_rvalid <= 1'b1; o_rdata <= i_rd_data; o_rresp <= i_rd_resp;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

endmodule

// >>> hw/cwd_config_top.sv
// Configuration word loader: captures the nonvolatile word after reset,
// decodes it into static controls and exposes them over AXI4-Lite.
// Assumes the word and straps are stable from reset until power down.
`timescale 1ns/1ns
`include "cwd_cfg_map.svh"

// Functional notes
// (RL1) Bit 13 low protects program memory range
// (RL2) Bit 12 routes capture unit two pin
// (RL3) Bit 11 low enables debugger, takes pins
// (RL4) Bits 10 and 9 read as one
// (RL5) Bits 8-7 choose brown-out trip level
// (RL6) Enable and mode pair set brown-out policy
// (RL7) Bit 5 selects reset pin or input
// (RL8) Bit 3 low enables power-up timer
// (RL9) Bit 2 high enables watchdog timer
// (RL10) Oscillator codes 1xx: RC sources, pin use
// (RL11) Oscillator codes 0xx: clock input, crystals
// (RL12) Firmware leaves address zero, last words
// (RL13) Firmware avoids debugger data locations
// (RL14) Unprotected memory may be read out
// (RL15) Controls latched once after reset, held
module cwd_config_top (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // AXI4-Lite write address
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  // AXI4-Lite write response
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  // AXI4-Lite read data
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // Nonvolatile storage and straps
  input  wire logic [13:0] i_nv_cfg_word,
  input  wire logic        i_nv_brownout_mode,
  input  wire logic        i_large_part,
  // Live system conditions
  input  wire logic        i_sleep,
  input  wire logic        i_reset_pin_level_n,
  // Program memory verify port
  output logic [12:0]      o_pm_rd_addr,
  input  wire logic [13:0] i_pm_rd_data,
  // Load state
  output logic             o_cfg_loaded,
  // Memory protection
  output logic             o_code_protect_on,
  output logic [12:0]      o_protect_top,
  output logic             o_pm_readout_allow,
  // Capture/compare pin routing
  output logic             o_capcomp2_on_portc_pin1,
  output logic             o_capcomp2_on_portb_pin3,
  // Debugger
  output logic             o_debug_enable,
  output logic             o_portb_pin6_dedicated,
  output logic             o_portb_pin7_dedicated,
  output logic [12:0]      o_dbg_rsv_base,
  // Brown-out
  output cwd_pkg::cwd_borv_e o_brownout_threshold_sel,
  output cwd_pkg::cwd_bor_e  o_brownout_policy,
  output logic             o_brownout_active,
  // Reset pin
  output logic             o_reset_pin_is_ext,
  output logic             o_porte_pin3_input,
  output logic             o_external_reset_n,
  // Timers
  output logic             o_powerup_timer_enable,
  output logic             o_watchdog_enable,
  // Oscillator
  output cwd_pkg::cwd_osc_e  o_oscillator_select,
  output logic             o_clock_out_en,
  output logic             o_osc_pin_one_port,
  output logic             o_osc_pin_two_port
);

  // Load sequence and captured word
  cwd_pkg::cwd_load_e ld_state_q;
  logic [13:0]        cfg_q;         // Captured word
  logic               bor_mode_q;    // Captured policy bit
  logic               large_q;       // Captured size strap

  // Software state
  logic               soft_bor_q;    // Brown-out soft enable
  logic [12:0]        vfy_addr_q;    // Verify address
  logic [13:0]        vfy_data_q;    // Verify data sample
  logic               vfy_block_q;   // Sample was withheld

  // Bus wires between front end and register file
  logic               wr_en;
  logic [7:0]         wr_addr;
  logic [31:0]        wr_data;
  logic [3:0]         wr_strb;
  logic               rd_en;
  logic [7:0]         rd_addr;
  logic [1:0]         wr_resp;       // Response to the write
  logic [31:0]        rd_data;       // Read data to the front end
  logic [1:0]         rd_resp;       // Response to the read

  // Decoded fields from the captured word
  cwd_pkg::cwd_osc_e  dec_osc;
  cwd_pkg::cwd_bor_e  dec_bor;
  cwd_pkg::cwd_borv_e dec_borv;
  logic               dec_protect;
  logic               dec_ccp_portc;
  logic               dec_debug;
  logic               dec_rst_ext;
  logic               dec_powerup_timer;
  logic               dec_wdt;
  logic               dec_clkout;
  logic               dec_osc_one;
  logic               dec_osc_two;

  // Bus front end
  cwd_axil_slave u_bus (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_awaddr  (i_awaddr),
    .i_awvalid (i_awvalid),
    .o_awready (o_awready),
    .i_wdata   (i_wdata),
    .i_wstrb   (i_wstrb),
    .i_wvalid  (i_wvalid),
    .o_wready  (o_wready),
    .o_bresp   (o_bresp),
    .o_bvalid  (o_bvalid),
    .i_bready  (i_bready),
    .i_araddr  (i_araddr),
    .i_arvalid (i_arvalid),
    .o_arready (o_arready),
    .o_rdata   (o_rdata),
    .o_rresp   (o_rresp),
    .o_rvalid  (o_rvalid),
    .i_rready  (i_rready),
    .o_wr_en   (wr_en),
    .o_wr_addr (wr_addr),
    .o_wr_data (wr_data),
    .o_wr_strb (wr_strb),
    .i_wr_resp (wr_resp),
    .o_rd_en   (rd_en),
    .o_rd_addr (rd_addr),
    .i_rd_data (rd_data),
    .i_rd_resp (rd_resp)
  );
  // Field decode of the held word
  cwd_field_decode u_dec (
    .i_word              (cfg_q),
    .i_brownout_mode_cfg (bor_mode_q),
    .o_osc               (dec_osc),
    .o_bor               (dec_bor),
    .o_borv              (dec_borv),
    .o_protect           (dec_protect),
    .o_ccp_on_portc      (dec_ccp_portc),
    .o_debug_en          (dec_debug),
    .o_rst_pin_ext       (dec_rst_ext),
    .o_powerup_timer_en           (dec_powerup_timer),
    .o_wdt_en            (dec_wdt),
    .o_clock_out         (dec_clkout),
    .o_osc_one_port      (dec_osc_one),
    .o_osc_two_port      (dec_osc_two)
  );
  // Address decode
  wire logic hit_cfg  = (wr_addr == `CWD_OFF_CFG_WORD);
  wire logic hit_sts  = (wr_addr == `CWD_OFF_STATUS);
  wire logic hit_pwr  = (wr_addr == `CWD_OFF_PWR_CTRL);
  wire logic hit_vad  = (wr_addr == `CWD_OFF_VFY_ADDR);
  wire logic hit_vdt  = (wr_addr == `CWD_OFF_VFY_DATA);
  wire logic wr_known = hit_cfg | hit_sts | hit_pwr | hit_vad | hit_vdt;
  // Read-only targets accept and drop writes; unmapped ones error
  assign wr_resp = wr_known ? `CWD_RESP_OKAY : `CWD_RESP_SLVERR;

  // Write strobes per register
  wire logic pwr_we  = wr_en & hit_pwr & wr_strb[0];
  wire logic vad_we0 = wr_en & hit_vad & wr_strb[0];
  wire logic vad_we1 = wr_en & hit_vad & wr_strb[1];
  // Protected range top depends on part size
  wire logic [12:0] prot_top = large_q ? `CWD_PROT_TOP_BIG
                                       : `CWD_PROT_TOP_SML; // RL1
  // The whole array is covered, so any address at or below top is locked
  wire logic vfy_locked = dec_protect & (vfy_addr_q <= prot_top); // RL1
  // Debugger keeps the last block of words at the top of memory
  wire logic [12:0] dbg_base = prot_top - `CWD_DBG_RSV_WORDS
                               + 13'h0001; // RL12

  // Brown-out detector on or off right now
  logic bor_now;
  always_comb begin
    unique case (dec_bor)
      cwd_pkg::CWD_BOR_ALWAYS:   bor_now = 1'b1;       // RL6
      cwd_pkg::CWD_BOR_RUN_ONLY: bor_now = ~i_sleep;   // RL6
      cwd_pkg::CWD_BOR_SOFT:     bor_now = soft_bor_q; // RL6
      cwd_pkg::CWD_BOR_OFF:      bor_now = 1'b0;       // RL6
    endcase
  end

  // Status word, bit positions fixed for software
  wire logic [31:0] status_word = {
    16'h0000,
    large_q,          // 15
    dec_bor,          // 14:13
    dec_borv,         // 12:11
    dec_osc,          // 10:8
    dec_rst_ext,      // 7
    dec_ccp_portc,    // 6
    dec_powerup_timer,         // 5
    dec_wdt,          // 4
    bor_now,          // 3
    dec_debug,        // 2
    dec_protect,      // 1
    o_cfg_loaded      // 0
  };

  // Read decode
  wire logic rd_cfg = (rd_addr == `CWD_OFF_CFG_WORD);
  wire logic rd_sts = (rd_addr == `CWD_OFF_STATUS);
  wire logic rd_pwr = (rd_addr == `CWD_OFF_PWR_CTRL);
  wire logic rd_vad = (rd_addr == `CWD_OFF_VFY_ADDR);
  wire logic rd_vdt = (rd_addr == `CWD_OFF_VFY_DATA);
  wire logic rd_known = rd_cfg | rd_sts | rd_pwr | rd_vad | rd_vdt;
  // Read data mux; unmapped reads return zero with an error
  assign rd_data = rd_cfg ? {18'h00000, cfg_q} :
                   rd_sts ? status_word :
                   rd_pwr ? {31'h00000000, soft_bor_q} :
                   rd_vad ? {19'h00000, vfy_addr_q} :
                   rd_vdt ? {17'h00000, vfy_block_q, vfy_data_q} :
                            32'h00000000;
  assign rd_resp = rd_known ? `CWD_RESP_OKAY : `CWD_RESP_SLVERR;

  // Capture one edge after release; ports cannot load under reset
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ld_state_q <= cwd_pkg::CWD_LD_WAIT;
      cfg_q      <= `CWD_CFG_RST;
      bor_mode_q <= 1'b0;
      large_q    <= 1'b0;
    end else begin
      unique case (ld_state_q)
        // Take the word and force the missing bits high
        cwd_pkg::CWD_LD_WAIT: begin
          cfg_q      <= i_nv_cfg_word | `CWD_UNIMP_MASK; // RL15 RL4
          bor_mode_q <= i_nv_brownout_mode;              // RL15
          large_q    <= i_large_part;                    // RL15
          ld_state_q <= cwd_pkg::CWD_LD_DONE;
        end
        // Held until the next reset
        cwd_pkg::CWD_LD_DONE: begin
          ld_state_q <= cwd_pkg::CWD_LD_DONE;            // RL15
        end
      endcase
    end
  end

  // Software brown-out enable, only acts in soft policy
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      soft_bor_q <= `CWD_PWR_CTRL_RST;
    end else if (pwr_we) begin
      soft_bor_q <= wr_data[0]; // RL6
    end
  end

  // Verify address, byte lanes honoured
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vfy_addr_q <= `CWD_VFY_ADDR_RST;
    end else begin
      if (vad_we0) begin
        vfy_addr_q[7:0] <= wr_data[7:0];
      end
      if (vad_we1) begin
        vfy_addr_q[12:8] <= wr_data[12:8];
      end
    end
  end

  // Verify sample; protected words read as zero with the block flag.
  // Sampled every cycle, so allow two cycles after an address write.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vfy_data_q  <= `CWD_VFY_DATA_RST;
      vfy_block_q <= 1'b1;
    end else if (vfy_locked || !o_cfg_loaded) begin
      vfy_data_q  <= `CWD_VFY_DATA_RST; // RL1
      vfy_block_q <= 1'b1;
    end else begin
      vfy_data_q  <= i_pm_rd_data; // RL14
      vfy_block_q <= 1'b0;
    end
  end
  assign o_pm_rd_addr = vfy_addr_q;

  // Static controls; safe values until the word has been taken:
  // protection on, debugger off, timers and brown-out off
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cfg_loaded             <= 1'b0;
      o_code_protect_on        <= 1'b1;
      o_protect_top            <= `CWD_PROT_TOP_SML;
      o_pm_readout_allow       <= 1'b0;
      o_capcomp2_on_portc_pin1 <= 1'b0;
      o_capcomp2_on_portb_pin3 <= 1'b0;
      o_debug_enable           <= 1'b0;
      o_portb_pin6_dedicated   <= 1'b0;
      o_portb_pin7_dedicated   <= 1'b0;
      o_dbg_rsv_base           <= `CWD_PROT_TOP_SML;
      o_brownout_threshold_sel <= cwd_pkg::CWD_BORV_4V5;
      o_brownout_policy        <= cwd_pkg::CWD_BOR_OFF;
      o_reset_pin_is_ext       <= 1'b1;
      o_porte_pin3_input       <= 1'b0;
      o_powerup_timer_enable   <= 1'b0;
      o_watchdog_enable        <= 1'b0;
      o_oscillator_select      <= cwd_pkg::CWD_OSC_LP_XTAL;
      o_clock_out_en           <= 1'b0;
      o_osc_pin_one_port       <= 1'b0;
      o_osc_pin_two_port       <= 1'b0;
    end else if (ld_state_q == cwd_pkg::CWD_LD_DONE) begin
      o_cfg_loaded             <= 1'b1;                 // RL15
      o_code_protect_on        <= dec_protect;          // RL1
      o_protect_top            <= prot_top;             // RL1
      o_pm_readout_allow       <= ~dec_protect;         // RL14
      o_capcomp2_on_portc_pin1 <= dec_ccp_portc;        // RL2
      o_capcomp2_on_portb_pin3 <= ~dec_ccp_portc;       // RL2
      o_debug_enable           <= dec_debug;            // RL3
      o_portb_pin6_dedicated   <= dec_debug;            // RL3
      o_portb_pin7_dedicated   <= dec_debug;            // RL3
      o_dbg_rsv_base           <= dbg_base;             // RL12
      o_brownout_threshold_sel <= dec_borv;             // RL5
      o_brownout_policy        <= dec_bor;              // RL6
      o_reset_pin_is_ext       <= dec_rst_ext;          // RL7
      o_porte_pin3_input       <= ~dec_rst_ext;         // RL7
      o_powerup_timer_enable   <= dec_powerup_timer;             // RL8
      o_watchdog_enable        <= dec_wdt;              // RL9
      o_oscillator_select      <= dec_osc;              // RL10 RL11
      o_clock_out_en           <= dec_clkout;           // RL10
      o_osc_pin_one_port       <= dec_osc_one;          // RL10
      o_osc_pin_two_port       <= dec_osc_two;          // RL10 RL11
    end
  end

  // Live signals follow sleep, software and the pin with one flop
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_brownout_active  <= 1'b0;
      o_external_reset_n <= 1'b1;
    end else begin
      o_brownout_active  <= o_cfg_loaded & bor_now; // RL6
      // Pin as input only: internal reset held inactive
      o_external_reset_n <= (o_cfg_loaded & dec_rst_ext)
                            ? i_reset_pin_level_n : 1'b1; // RL7
    end
  end

endmodule

// >>> testbench/cwd_config_sva.sv
// Assertions on the decoded configuration controls.
// Assumes binding onto cwd_config_top; sees its ports only.
`timescale 1ns/1ns
module cwd_config_sva (
  // Clock, reset and strap
  input wire logic         i_sys_clk,
  input wire logic         i_rst_n,
  input wire logic         i_large_part,
  // Decoded controls
  input wire logic         o_cfg_loaded,
  input wire logic         o_code_protect_on,
  input wire logic [12:0]  o_protect_top,
  input wire logic         o_pm_readout_allow,
  input wire logic         o_capcomp2_on_portc_pin1,
  input wire logic         o_capcomp2_on_portb_pin3,
  input wire logic         o_debug_enable,
  input wire logic         o_portb_pin6_dedicated,
  input cwd_pkg::cwd_bor_e o_brownout_policy,
  input wire logic         o_brownout_active,
  input wire logic         o_reset_pin_is_ext,
  input wire logic         o_external_reset_n,
  input cwd_pkg::cwd_osc_e o_oscillator_select,
  input wire logic         o_clock_out_en
);
  // All checks in the one clock domain
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  chk_protect_top: assert property (o_cfg_loaded |->
    o_protect_top == (i_large_part ? 13'h1FFF : 13'h0FFF))
    else $error("protected range top wrong");
  chk_readout_gate: assert property (o_cfg_loaded |->
    o_pm_readout_allow == !o_code_protect_on) else $error("readout gate");
  chk_capcomp_route: assert property (o_cfg_loaded |->
    o_capcomp2_on_portc_pin1 != o_capcomp2_on_portb_pin3)
    else $error("capture pin on both or none");
  chk_debug_pins: assert property (o_cfg_loaded |->
    o_portb_pin6_dedicated == o_debug_enable) else $error("debug pins");
  chk_bor_fixed: assert property (o_cfg_loaded &&
    o_brownout_policy[1] == o_brownout_policy[0] |=>
    o_brownout_active == o_brownout_policy[1]) else $error("brown-out");
  chk_reset_gated: assert property (o_cfg_loaded &&
    !o_reset_pin_is_ext |=> o_external_reset_n) else $error("reset gate");
  chk_clock_out: assert property (o_cfg_loaded |->
    o_clock_out_en == (o_oscillator_select[2] && o_oscillator_select[0]))
    else $error("clock out enable");
  chk_held_stable: assert property (o_cfg_loaded && $past(o_cfg_loaded)
    |-> $stable(o_oscillator_select) && $stable(o_code_protect_on))
    else $error("controls changed after load");
endmodule
bind cwd_config_top cwd_config_sva u_sva (.*);

// >>> testbench/tb_top.sv
// Bench for the configuration decoder: eight words, reset and check.
// Assumes the AXI4-Lite slave starts idle and ready after reset.
`timescale 1ns/1ns
module tb_top;
  logic        i_sys_clk, i_rst_n, i_awvalid, i_wvalid, i_bready;
  logic        i_arvalid, i_rready, i_nv_brownout_mode, i_large_part;
  logic        i_sleep, o_awready, o_wready, o_bvalid, o_arready;
  logic        o_rvalid, o_cfg_loaded, o_code_protect_on;
  logic        o_capcomp2_on_portc_pin1, o_debug_enable, o_brownout_active;
  logic        o_reset_pin_is_ext, o_external_reset_n, o_watchdog_enable;
  logic        o_powerup_timer_enable, i_reset_pin_level_n, o_porte_pin3_input;
  logic        o_portb_pin7_dedicated, o_osc_pin_one_port, o_osc_pin_two_port;
  logic [7:0]  i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, rd;
  logic [13:0] i_nv_cfg_word, w;
  logic [12:0] o_protect_top, o_dbg_rsv_base, o_pm_rd_addr;
  logic [2:0]  b;
  logic [1:0]  o_bresp, o_rresp, rr, br;
  cwd_pkg::cwd_borv_e o_brownout_threshold_sel;
  cwd_pkg::cwd_bor_e  o_brownout_policy;
  cwd_pkg::cwd_osc_e  o_oscillator_select;
  int          n_errors, n_checks;
  // Verify data tied; reset pin level set per test
  cwd_config_top uut (.*, .i_wstrb(4'hF), .i_pm_rd_data(14'h2C5D),
    .o_pm_readout_allow(), .o_capcomp2_on_portb_pin3(),
    .o_portb_pin6_dedicated(), .o_clock_out_en());
  // Clock, 10 ns period
  initial begin
    i_sys_clk = 0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Both write channels offered together, each released once taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    i_awaddr <= a; i_wdata <= d; i_awvalid <= 1; i_wvalid <= 1;
    i_bready <= 1;
    do begin
      @(posedge i_sys_clk);
      if (i_awvalid && o_awready) i_awvalid <= 0;
      if (i_wvalid && o_wready) i_wvalid <= 0;
    end while (!o_bvalid);
    br = o_bresp; i_bready <= 0;
    @(posedge i_sys_clk);
  endtask
  task rdr(input logic [7:0] a);
    i_araddr <= a; i_arvalid <= 1;
    do @(posedge i_sys_clk); while (!o_arready);
    i_arvalid <= 0; i_rready <= 1;
    do @(posedge i_sys_clk); while (!o_rvalid);
    rd = o_rdata; rr = o_rresp; i_rready <= 0;
    @(posedge i_sys_clk);
  endtask
  task results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Watchdog: 10000 cycles, far above what eight loads take
  initial begin
    #100000;
    n_errors++;
    results;
  end
  initial begin
    {i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 0;
    {i_awaddr, i_araddr, i_wdata, i_nv_cfg_word} = 0;
    {i_nv_brownout_mode, i_large_part, i_sleep, i_reset_pin_level_n} = 0;
    // No data-memory traffic: debugger locations stay free
    // Index bits walk every oscillator, level and policy code
    for (int i = 0; i < 8; i++) begin
      b = i[2:0];
      w = {b[0], ~b[0], b[1], 2'b00, b[1:0], b[2], b[0], b[2], ~b[0],
        b[2], b[1:0]};
      i_nv_cfg_word <= w; i_large_part <= b[0];
      i_sleep <= b[0]; i_nv_brownout_mode <= b[1]; i_rst_n <= 0;
      i_reset_pin_level_n <= b[1];
      repeat (10) @(posedge i_sys_clk);
      i_rst_n <= 1;
      repeat (3) @(posedge i_sys_clk);
      i_nv_cfg_word <= ~w; // Must be ignored until next reset
      wr(8'h08, 32'h1); wr(8'h0C, 32'h0123);
      wr(8'h00, 32'h0); chk(br, 2'h0);
      rdr(8'h00); chk(rd, {18'h0, w | 14'h0600});
      rdr(8'h10); chk(rd, b[0] ? 32'h2C5D : 32'h4000);
      chk(o_code_protect_on, !b[0]);
      chk(o_protect_top, b[0] ? 13'h1FFF : 13'h0FFF);
      chk(o_capcomp2_on_portc_pin1, !b[0]);
      chk(o_debug_enable, !b[1]);
      chk(o_brownout_threshold_sel, b[1:0]);
      chk(o_brownout_policy, b[2:1]);
      chk(o_brownout_active, b[2] ? (b[1] | !b[0]) : b[1]);
      chk(o_external_reset_n, !b[0] | b[1]);
      chk(o_porte_pin3_input, !b[0]);
      chk(o_reset_pin_is_ext, b[0]);
      chk(o_powerup_timer_enable, b[0]);
      chk(o_watchdog_enable, b[2]);
      chk(o_oscillator_select, b);
      chk(o_cfg_loaded, 1);
      chk(o_dbg_rsv_base, b[0] ? 13'h1F00 : 13'h0F00);
      chk(o_portb_pin7_dedicated, !b[1]);
      chk(o_osc_pin_one_port, b == 3'h5 || b == 3'h4);
      chk(o_osc_pin_two_port, b == 3'h6 || b == 3'h4 || b == 3'h3);
      chk(o_pm_rd_addr, 13'h0123);
      $display("test %0d done", i);
    end
    rdr(8'h20); chk(rr, 2'h2);
    $display("unmapped test done");
    results;
  end
endmodule
